// >>> verilog/tfef_pkg.sv
// Purpose: Shared constants and types for the timer flop and event flag block
// Assumes: 32-bit AXI4-Lite data, 8-bit register byte addresses
// Notes:   Every offset and code used by the design lives here, and all field positions and reset values except the irq_mask write field and irq reset

package tfef_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  localparam logic [7:0] TFEF_OFS_FLOP_CTRL = 8'h00;
  localparam logic [7:0] TFEF_OFS_STATUS    = 8'h04;
  localparam logic [7:0] TFEF_OFS_IRQ_MASK  = 8'h08;

  // ==========================================================================
  // Flop control register fields
  // ==========================================================================
  localparam int unsigned TFEF_CODE_LSB   = 0;
  localparam int unsigned TFEF_CODE_MSB   = 1;
  localparam int unsigned TFEF_TOGGLE_LSB = 2;
  localparam int unsigned TFEF_TOGGLE_MSB = 5;
  localparam int unsigned TFEF_ONES_LSB   = 6;
  localparam int unsigned TFEF_ONES_MSB   = 7;

  localparam logic [1:0] TFEF_CODE_INVERT = 2'h0;
  localparam logic [1:0] TFEF_CODE_SET    = 2'h1;
  localparam logic [1:0] TFEF_CODE_CLEAR  = 2'h2;
  localparam logic [1:0] TFEF_CODE_KEEP   = 2'h3;

  // Fixed read-back patterns of the flop control register
  localparam logic [1:0]  TFEF_CODE_READ    = 2'h3;
  localparam logic [1:0]  TFEF_ONES_READ    = 2'h3;
  localparam logic [23:0] TFEF_UPPER_READ   = 24'h00_0000;

  // ==========================================================================
  // Status and mask fields (same layout)
  // ==========================================================================
  localparam int unsigned TFEF_FLAG_W       = 3;
  localparam int unsigned TFEF_BIT_MATCH0   = 0;
  localparam int unsigned TFEF_BIT_MATCH1   = 1;
  localparam int unsigned TFEF_BIT_OVERFLOW = 2;

  localparam logic [2:0]  TFEF_FLAGS_RESET  = 3'h0;
  localparam logic [2:0]  TFEF_MASK_RESET   = 3'h0;
  localparam logic [3:0]  TFEF_TOGGLE_RESET = 4'h0;
  localparam logic        TFEF_FLOP_RESET   = 1'b0;

  // ==========================================================================
  // AXI4-Lite responses
  // ==========================================================================
  localparam logic [1:0]  TFEF_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  TFEF_RESP_SLVERR  = 2'h2;
  localparam logic [31:0] TFEF_READ_ZERO    = 32'h0000_0000;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Flag-raising events, bit order equals the status register layout
  typedef struct packed {
    logic overflow;
    logic match1;
    logic match0;
  } tfef_evt_t;

  typedef struct packed {
    logic [2:0] flags;
    logic       irq;
  } tfef_flag_state_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [3:0]  toggle_en;
    logic [2:0]  irq_mask;
    logic        timer_output_flop;
  } tfef_main_state_t;

  localparam tfef_main_state_t TFEF_MAIN_RESET = '{
    awready: 1'b1,
    wready:  1'b1,
    arready: 1'b1,
    default: '0
  };

endpackage

// >>> verilog/tfef_flag_unit.sv
// Purpose: Sticky event flags with clear-on-read and a masked interrupt level
// Assumes: Events are one-cycle pulses synchronous to the clock
// Notes:   An event in the clearing cycle survives the clear

`timescale 1ns/10ps

module tfef_flag_unit (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire tfef_pkg::tfef_evt_t events,
  input  wire logic               read_clear,
  input  wire logic [2:0]         mask,
  output logic [2:0]              flags,
  output logic                    irq
);

  tfef_pkg::tfef_flag_state_t s;
  tfef_pkg::tfef_flag_state_t next_s;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_s = s;
    if (read_clear) begin
      next_s.flags = tfef_pkg::TFEF_FLAGS_RESET;
    end
    // Setting ignores the mask and wins over a simultaneous read clear
    next_s.flags = next_s.flags | events;
    // Only enabled flags reach the processor
    next_s.irq = |(next_s.flags & mask);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{flags: tfef_pkg::TFEF_FLAGS_RESET, irq: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign flags = s.flags;
  assign irq   = s.irq;

endmodule

// >>> verilog/tfef_timer_flop.sv
// Purpose: Timer output flop control and event flags of one timer channel
// Assumes: Counter, compare and capture logic sit in the host channel and
//          deliver one-cycle event pulses synchronous to CORE_CLK (20 MHz)
// Notes:   Registers reached over AXI4-Lite; all outputs come from flops

`timescale 1ns/10ps

module tfef_timer_flop (
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  // Events from the host timer channel, one-cycle pulses
  input  wire logic        CAPTURE0_EVT,
  input  wire logic        CAPTURE1_EVT,
  input  wire logic        MATCH0_EVT,
  input  wire logic        MATCH1_EVT,
  input  wire logic        OVERFLOW_EVT,
  // AXI4-Lite write address
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  // AXI4-Lite write response
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read address
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  // AXI4-Lite read data
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // Block outputs
  output logic             TIMER_OUTPUT_FLOP,
  output logic             IRQ
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  tfef_pkg::tfef_main_state_t s;
  tfef_pkg::tfef_main_state_t next_s;

  tfef_pkg::tfef_evt_t flag_events;
  logic [2:0]          flags;
  logic                flag_irq;
  logic                read_clear;

  logic [3:0]          toggle_events;
  logic                hw_toggle;
  logic                aw_take;
  logic                w_take;
  logic                ar_take;
  logic                do_write;
  logic [1:0]          code;

  // ==========================================================================
  // Event routing
  // ==========================================================================
  // Order matches the toggle enable field: capture1, capture0, match1, match0
  assign toggle_events = {CAPTURE1_EVT, CAPTURE0_EVT, MATCH1_EVT, MATCH0_EVT};

  // Simultaneous enabled events cancel in pairs, as sequential inversions would
  assign hw_toggle = ^(toggle_events & s.toggle_en);

  assign flag_events.overflow = OVERFLOW_EVT;
  assign flag_events.match1   = MATCH1_EVT;
  assign flag_events.match0   = MATCH0_EVT;

  // ==========================================================================
  // Bus handshakes
  // ==========================================================================
  assign aw_take  = AWVALID & s.awready;
  assign w_take   = WVALID & s.wready;
  assign ar_take  = ARVALID & s.arready;
  assign do_write = s.aw_full & s.w_full & ~s.bvalid;
  assign code     = s.wdata[tfef_pkg::TFEF_CODE_MSB:tfef_pkg::TFEF_CODE_LSB];

  // A status read clears the flags at the edge that raises RVALID
  assign read_clear = ar_take & (ARADDR == tfef_pkg::TFEF_OFS_STATUS);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_s = s;

    // Hardware toggles every cycle; software codes below act on top of them
    next_s.timer_output_flop = s.timer_output_flop ^ hw_toggle;

    // Write address and data are held independently until both are present
    if (aw_take) begin
      next_s.aw_full = 1'b1;
      next_s.awaddr  = AWADDR;
    end
    if (w_take) begin
      next_s.w_full = 1'b1;
      next_s.wdata  = WDATA;
      next_s.wstrb  = WSTRB;
    end

    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end

    if (do_write) begin
      next_s.aw_full = 1'b0;
      next_s.w_full  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = tfef_pkg::TFEF_RESP_OKAY;
      unique case (s.awaddr)
        tfef_pkg::TFEF_OFS_FLOP_CTRL: begin
          // Only byte lane 0 holds writable bits; upper bits are ignored
          if (s.wstrb[0]) begin
            next_s.toggle_en =
              s.wdata[tfef_pkg::TFEF_TOGGLE_MSB:tfef_pkg::TFEF_TOGGLE_LSB];
            unique case (code)
              tfef_pkg::TFEF_CODE_INVERT: begin
                next_s.timer_output_flop = ~next_s.timer_output_flop;
              end
              tfef_pkg::TFEF_CODE_SET: begin
                next_s.timer_output_flop = 1'b1;
              end
              tfef_pkg::TFEF_CODE_CLEAR: begin
                next_s.timer_output_flop = 1'b0;
              end
              tfef_pkg::TFEF_CODE_KEEP: begin
                next_s.timer_output_flop = next_s.timer_output_flop;
              end
            endcase
          end
        end
        tfef_pkg::TFEF_OFS_STATUS: begin
          // Read-only: a write neither sets nor clears any flag
          next_s.bresp = tfef_pkg::TFEF_RESP_OKAY;
        end
        tfef_pkg::TFEF_OFS_IRQ_MASK: begin
          if (s.wstrb[0]) begin
            next_s.irq_mask = s.wdata[2:0];
          end
        end
        default: begin
          next_s.bresp = tfef_pkg::TFEF_RESP_SLVERR;
        end
      endcase
    end

    next_s.awready = ~next_s.aw_full;
    next_s.wready  = ~next_s.w_full;

    // Read channel: one read in flight, data registered with RVALID
    if (s.rvalid && RREADY) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end

    if (ar_take) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rresp   = tfef_pkg::TFEF_RESP_OKAY;
      unique case (ARADDR)
        tfef_pkg::TFEF_OFS_FLOP_CTRL: begin
          next_s.rdata = {tfef_pkg::TFEF_UPPER_READ,
                          tfef_pkg::TFEF_ONES_READ,
                          s.toggle_en,
                          tfef_pkg::TFEF_CODE_READ};
        end
        tfef_pkg::TFEF_OFS_STATUS: begin
          next_s.rdata = {29'h0000_0000, flags};
        end
        tfef_pkg::TFEF_OFS_IRQ_MASK: begin
          next_s.rdata = {29'h0000_0000, s.irq_mask};
        end
        default: begin
          next_s.rdata = tfef_pkg::TFEF_READ_ZERO;
          next_s.rresp = tfef_pkg::TFEF_RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= tfef_pkg::TFEF_MAIN_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Event flags and interrupt
  // ==========================================================================
  tfef_flag_unit u_flags (
    .clk        (CORE_CLK),
    .arst_n     (ARST_N),
    .events     (flag_events),
    .read_clear (read_clear),
    .mask       (s.irq_mask),
    .flags      (flags),
    .irq        (flag_irq)
  );

  // ==========================================================================
  // Outputs, all taken from flops
  // ==========================================================================
  assign AWREADY           = s.awready;
  assign WREADY            = s.wready;
  assign BRESP             = s.bresp;
  assign BVALID            = s.bvalid;
  assign ARREADY           = s.arready;
  assign RDATA             = s.rdata;
  assign RRESP             = s.rresp;
  assign RVALID            = s.rvalid;
  assign TIMER_OUTPUT_FLOP = s.timer_output_flop;
  assign IRQ               = flag_irq;

endmodule

// >>> testbench/tfef_timer_flop_chk.sv
// Purpose: Port assertions for the timer flop and event flag block
// Assumes: One clock domain, asynchronous reset active low
// Notes:   Bound into every tfef_timer_flop instance
`timescale 1ns/10ps
module tfef_timer_flop_chk (
  input wire logic        CORE_CLK,
  input wire logic        ARST_N,
  input wire logic        CAPTURE0_EVT,
  input wire logic        CAPTURE1_EVT,
  input wire logic        MATCH0_EVT,
  input wire logic        MATCH1_EVT,
  input wire logic        OVERFLOW_EVT,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic        TIMER_OUTPUT_FLOP,
  input wire logic        IRQ
);
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);
  wire flag_evt = OVERFLOW_EVT | MATCH0_EVT | MATCH1_EVT;
  wire any_evt  = flag_evt | CAPTURE0_EVT | CAPTURE1_EVT;
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("Read data not returned one cycle after address");
  rd_cause_a: assert property ($rose(RVALID) |-> $past(ARVALID && ARREADY))
    else $error("Read data without a taken address");
  rd_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("Read data dropped or changed before taken");
  wr_hold_a: assert property (BVALID && !BREADY |=> BVALID)
    else $error("Write response dropped before taken");
  rd_busy_a: assert property (RVALID |-> !ARREADY)
    else $error("Read address accepted while data pending");
  flop_cause_a: assert property (
    $changed(TIMER_OUTPUT_FLOP) |-> $past(any_evt) || $rose(BVALID))
    else $error("Output flop changed without event or write");
  irq_rise_a: assert property ($rose(IRQ) |-> $past(flag_evt) || $past(BVALID))
    else $error("Interrupt rose without event or mask write");
  irq_fall_a: assert property (
    $fell(IRQ) |-> $past(ARVALID && ARREADY) || $past(BVALID))
    else $error("Interrupt fell without status read or mask write");
endmodule

bind tfef_timer_flop tfef_timer_flop_chk u_chk (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .CAPTURE0_EVT(CAPTURE0_EVT),
  .CAPTURE1_EVT(CAPTURE1_EVT), .MATCH0_EVT(MATCH0_EVT), .MATCH1_EVT(MATCH1_EVT),
  .OVERFLOW_EVT(OVERFLOW_EVT), .BVALID(BVALID), .BREADY(BREADY),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID),
  .RREADY(RREADY), .TIMER_OUTPUT_FLOP(TIMER_OUTPUT_FLOP), .IRQ(IRQ)
);

// >>> testbench/tfef_timer_flop_tb_top.sv
// Purpose: Self-checking bench for the timer flop and event flag block
// Assumes: Events are one-cycle pulses; AXI4-Lite master in this bench
// Notes:   Read and write answers are checked from queues by a monitor
`timescale 1ns/10ps
module tfef_timer_flop_tb_top;
  localparam logic [7:0] a_flop = tfef_pkg::TFEF_OFS_FLOP_CTRL;
  localparam logic [7:0] a_stat = tfef_pkg::TFEF_OFS_STATUS;
  localparam logic [7:0] a_mask = tfef_pkg::TFEF_OFS_IRQ_MASK;
  logic        clk = 1'h0;
  logic        arst_n = 1'h0;
  logic [4:0]  evt = 5'h00;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, flop, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [31:0] rnd = 32'h0000_5E63;
  logic [9:0]  seq = {2'h2, 2'h0, 2'h3, 2'h0, 2'h1};
  logic [1:0]  c;
  logic        f = tfef_pkg::TFEF_FLOP_RESET;
  int          err_count = 0;
  int          tests_run = 0;
  int          fb;

  tfef_timer_flop u_dut (
    .CORE_CLK(clk), .ARST_N(arst_n), .CAPTURE0_EVT(evt[3]), .CAPTURE1_EVT(evt[4]),
    .MATCH0_EVT(evt[1]), .MATCH1_EVT(evt[2]), .OVERFLOW_EVT(evt[0]),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
    .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .TIMER_OUTPUT_FLOP(flop), .IRQ(irq)
  );

  always #25 clk = ~clk;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [33:0] ok(input logic [31:0] d);
    return {tfef_pkg::TFEF_RESP_OKAY, d};
  endfunction
  task chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge clk); while (!bvalid);
    bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'h0;
  endtask
  task pulse(input logic [4:0] e);
    evt <= e;
    @(posedge clk);
    evt <= 5'h00;
  endtask
  task see(input logic ef, input logic eq);
    #1;
    chk(34'(flop), 34'(ef));
    chk(34'(irq), 34'(eq));
  endtask

  // ==========================================================================
  // Monitor and watchdog
  always @(posedge clk) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk(34'(bresp), 34'(bq.pop_front()));
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    rd(a_flop, ok(32'h0000_00C3));
    rd(a_stat, ok(32'h0000_0000));
    rd(a_mask, ok(32'h0000_0000));
    see(f, 1'h0);
    for (int i = 0; i < 5; i++) begin
      c = seq[2*i +: 2];
      rnd = lfsr(rnd);
      wr(a_flop, {rnd[31:6], 4'h0, c}, tfef_pkg::TFEF_RESP_OKAY);
      f = (c == 2'h0) ? !f : (c == 2'h1) ? 1'h1 : (c == 2'h2) ? 1'h0 : f;
      see(f, 1'h0);
      rd(a_flop, ok(32'h0000_00C3));
    end
    wstrb <= 4'hE;
    wr(a_flop, 32'h0000_0001, tfef_pkg::TFEF_RESP_OKAY);
    wstrb <= 4'hF;
    see(f, 1'h0);
    for (int i = 0; i < 4; i++) begin
      wr(a_flop, 32'h0000_0003 | (32'h0000_0004 << i), tfef_pkg::TFEF_RESP_OKAY);
      rd(a_flop, ok(32'h0000_00C3 | (32'h0000_0004 << i)));
      for (int j = 1; j < 5; j++) begin
        pulse(5'h01 << j);
        f = f ^ (j == i + 1);
        see(f, 1'h0);
      end
      rd(a_stat, ok(32'h0000_0003));
    end
    rd(a_stat, ok(32'h0000_0000));
    pulse(5'h01);
    wr(a_stat, 32'hFFFF_FFFF, tfef_pkg::TFEF_RESP_OKAY);
    rd(a_stat, ok(32'h0000_0004));
    for (int b = 0; b < 3; b++) begin
      wr(a_mask, 32'h0000_0001 << b, tfef_pkg::TFEF_RESP_OKAY);
      rd(a_mask, ok(32'h0000_0001 << b));
      for (int k = 0; k < 3; k++) begin
        pulse(5'h01 << k);
        fb = (k == 0) ? 2 : k - 1;
        see(f, fb == b);
        rd(a_stat, ok(32'h0000_0001 << fb));
        see(f, 1'h0);
      end
    end
    rnd = lfsr(rnd);
    wr(a_mask, rnd, tfef_pkg::TFEF_RESP_OKAY);
    rd(a_mask, ok({29'h0000_0000, rnd[2:0]}));
    pulse(5'h07);
    see(f, |rnd[2:0]);
    rd(a_stat, ok(32'h0000_0007));
    wr(8'h0C, 32'h0000_0001, tfef_pkg::TFEF_RESP_SLVERR);
    rd(8'h0C, {tfef_pkg::TFEF_RESP_SLVERR, tfef_pkg::TFEF_READ_ZERO});
    see(f, 1'h0);
    end_of_test();
  end
endmodule
